// ---- core/node_cfg_pkg.sv ----
// shared constants and types for the node configuration and guard objects
package node_cfg_pkg;
  // dictionary indices and sub-indices
  localparam logic [15:0] IDX_ERROR   = 16'h1001;
  localparam logic [15:0] IDX_GUARD   = 16'h100C;
  localparam logic [15:0] IDX_RETRY   = 16'h100D;
  localparam logic [15:0] IDX_SIG     = 16'h1020;
  localparam logic [15:0] IDX_MODULES = 16'h1027;
  localparam logic [7:0]  SUB_COUNT   = 8'h00;
  localparam logic [7:0]  SUB_DATE    = 8'h01;
  localparam logic [7:0]  SUB_TIME    = 8'h02;
  localparam logic [7:0]  SIG_ENTRIES = 8'h02;
  localparam logic [7:0]  MAX_MODULES = 8'h4A;
  // values after reset
  localparam logic [15:0] GUARD_RESET = 16'h0000;
  localparam logic [7:0]  RETRY_RESET = 8'h00;
  localparam logic [31:0] SIG_CLEAR   = 32'h0000_0000;
  // error summary bit positions
  localparam int ERR_GENERAL = 0;
  localparam int ERR_CURRENT = 1;
  localparam int ERR_VOLTAGE = 2;
  localparam int ERR_COMM    = 4;
  localparam int ERR_VENDOR  = 7;
  // module identifier base, value arbitrary
  localparam logic [15:0] MODULE_ID_BASE = 16'h4100;
  // guard answer identifier base, value arbitrary
  localparam logic [10:0] GUARD_ID_BASE  = 11'h700;
  // guard time unit: one millisecond
  localparam int CLK_PERIOD_NS = 40;
  localparam int GUARD_UNIT_NS = 1000000;
  localparam int MS_CYCLES     = GUARD_UNIT_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic        wr;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } od_req_type;

  typedef struct packed {
    logic [31:0] days;
    logic [31:0] msecs;
  } signature_type;

  typedef struct packed {
    logic general;
    logic current;
    logic voltage;
    logic comm;
    logic vendor;
  } fault_type;

  typedef struct packed {
    logic          valid;
    signature_type sig;
    logic [15:0]   guard;
    logic [7:0]    retry;
  } nv_image_type;

  typedef enum logic [1:0] {
    BOOT_WAIT = 2'b00,
    RUNNING   = 2'b01
  } boot_state_type;
endpackage

// ---- core/node_config_guard_objects.sv ----
// dictionary entries for configuration signature, module list, errors and guarding
// Functional notes
// - any config change other than signature write zeroes the signature
// - after reset restore stored config and signature, automatically or on request
// - date sub-entry: 32-bit day count since January 01 1984
// - time sub-entry: 32-bit milliseconds since midnight
// - module list sub-index 00 reads installed module count, read-only
// - sub-indices 01 to 4A hold 16-bit ids in installation order
// - one fixed identifier per module type
// - error byte: bits 0,1,2,4,7 faults, bits 3,5,6 zero
// - node answers each guard request with its guard identifier while guard time and factor are both nonzero
`timescale 1ns/1ps
module node_config_guard_objects #(
  parameter int MS_COUNT = node_cfg_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // dictionary access
  input  wire logic                       od_req,
  input  wire node_cfg_pkg::od_req_type   od_cmd,
  output logic                            od_ack_q,
  output logic                            od_abort_q,
  output logic [31:0]                     od_rdata_q,
  // signature save by the configuration tool
  input  wire logic                       sig_wr,
  input  wire node_cfg_pkg::signature_type sig_in,
  // stored image and restore control
  input  wire node_cfg_pkg::nv_image_type nv_image,
  input  wire logic                       auto_restore,
  input  wire logic                       restore_req,
  output logic                            restored_q,
  // station modules
  input  wire logic                       mod_wr,
  input  wire logic [6:0]                 mod_slot,
  input  wire logic [7:0]                 mod_type,
  input  wire logic [6:0]                 mod_count,
  // fault sources
  input  wire node_cfg_pkg::fault_type    faults,
  // node guarding
  input  wire logic [6:0]                 node_id,
  input  wire logic                       guard_rx,
  output logic                            guard_tx_q,
  output logic [10:0]                     guard_cob_q,
  output logic                            life_lost_q
);
  // identifier for a module type, same for every module of that type
  function automatic logic [15:0] type_id(input logic [7:0] t);
    type_id = node_cfg_pkg::MODULE_ID_BASE + {8'h00, t};
  endfunction

  // state
  node_cfg_pkg::boot_state_type boot_q;
  node_cfg_pkg::signature_type  sig_q;
  logic [15:0] guard_q;
  logic [7:0]  retry_q;
  logic [7:0]  err_q;
  logic [6:0]  count_q;
  logic [15:0] mod_list [0:73];
  logic [31:0] tick_q;
  logic [23:0] elapsed_q;
  logic        armed_q;

  // decode of the dictionary request
  wire logic hit_err   = od_cmd.index == node_cfg_pkg::IDX_ERROR;
  wire logic hit_guard = od_cmd.index == node_cfg_pkg::IDX_GUARD;
  wire logic hit_retry = od_cmd.index == node_cfg_pkg::IDX_RETRY;
  wire logic hit_sig   = od_cmd.index == node_cfg_pkg::IDX_SIG;
  wire logic hit_mods  = od_cmd.index == node_cfg_pkg::IDX_MODULES;
  wire logic sub0      = od_cmd.sub == node_cfg_pkg::SUB_COUNT;
  wire logic mod_sel   = od_cmd.sub != node_cfg_pkg::SUB_COUNT
                         && od_cmd.sub <= {1'b0, count_q};
  wire logic sig_sel   = od_cmd.sub <= node_cfg_pkg::SIG_ENTRIES;
  wire logic rw_obj    = (hit_guard || hit_retry) && sub0;
  wire logic ro_ok     = (hit_err && sub0) || (hit_sig && sig_sel)
                         || (hit_mods && (sub0 || mod_sel));
  wire logic wr_guard  = od_req && od_cmd.wr && hit_guard && sub0;
  wire logic wr_retry  = od_req && od_cmd.wr && hit_retry && sub0;
  wire logic req_bad   = od_cmd.wr ? !rw_obj : !(ro_ok || rw_obj);
  wire logic [6:0] mod_idx = od_cmd.sub[6:0] - 7'd1;

  // restore trigger: once after reset when enabled, or on request
  wire logic do_restore = nv_image.valid
                          && ((boot_q == node_cfg_pkg::BOOT_WAIT && auto_restore)
                              || (boot_q == node_cfg_pkg::RUNNING && restore_req));
  wire logic cfg_change = wr_guard || wr_retry;

  // read data selection
  logic [31:0] rd_sel;
  always_comb begin
    rd_sel = 32'h0000_0000;
    if (hit_err) begin
      rd_sel = {24'h00_0000, err_q};
    end else if (hit_guard) begin
      rd_sel = {16'h0000, guard_q};
    end else if (hit_retry) begin
      rd_sel = {24'h00_0000, retry_q};
    end else if (hit_sig) begin
      if (od_cmd.sub == node_cfg_pkg::SUB_DATE) begin
        rd_sel = sig_q.days;
      end else if (od_cmd.sub == node_cfg_pkg::SUB_TIME) begin
        rd_sel = sig_q.msecs;
      end else begin
        rd_sel = {24'h00_0000, node_cfg_pkg::SIG_ENTRIES};
      end
    end else if (hit_mods) begin
      if (sub0) begin
        rd_sel = {25'h000_0000, count_q};
      end else begin
        rd_sel = {16'h0000, mod_list[mod_idx]};
      end
    end
  end

  // dictionary answer one cycle after the request
  always_ff @(posedge core_clk) begin
    if (rst) begin
      od_ack_q   <= 1'b0;
      od_abort_q <= 1'b0;
      od_rdata_q <= 32'h0000_0000;
    end else begin
      od_ack_q   <= od_req;
      od_abort_q <= od_req && req_bad;
      od_rdata_q <= (od_req && !od_cmd.wr && !req_bad) ? rd_sel : 32'h0000_0000;
    end
  end

  // boot sequencing: auto restore gets one chance right after reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      boot_q     <= node_cfg_pkg::BOOT_WAIT;
      restored_q <= 1'b0;
    end else begin
      boot_q     <= node_cfg_pkg::RUNNING;
      restored_q <= do_restore;
    end
  end

  // configuration and signature; restore wins over a same-cycle write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      guard_q <= node_cfg_pkg::GUARD_RESET;
      retry_q <= node_cfg_pkg::RETRY_RESET;
      sig_q   <= {node_cfg_pkg::SIG_CLEAR, node_cfg_pkg::SIG_CLEAR};
    end else if (do_restore) begin
      guard_q <= nv_image.guard;
      retry_q <= nv_image.retry;
      sig_q   <= nv_image.sig;
    end else begin
      if (wr_guard) begin
        guard_q <= od_cmd.wdata[15:0];
      end
      if (wr_retry) begin
        retry_q <= od_cmd.wdata[7:0];
      end
      if (cfg_change) begin
        sig_q <= {node_cfg_pkg::SIG_CLEAR, node_cfg_pkg::SIG_CLEAR};
      end else if (sig_wr) begin
        sig_q <= sig_in;
      end
    end
  end

  // error byte; unused bits held at zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      err_q <= 8'h00;
    end else begin
      err_q <= 8'h00;
      err_q[node_cfg_pkg::ERR_GENERAL] <= faults.general;
      err_q[node_cfg_pkg::ERR_CURRENT] <= faults.current;
      err_q[node_cfg_pkg::ERR_VOLTAGE] <= faults.voltage;
      err_q[node_cfg_pkg::ERR_COMM]    <= faults.comm;
      err_q[node_cfg_pkg::ERR_VENDOR]  <= faults.vendor;
    end
  end

  // count clamped to the list depth
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_q <= 7'd0;
    end else begin
      count_q <= (mod_count > node_cfg_pkg::MAX_MODULES[6:0])
                 ? node_cfg_pkg::MAX_MODULES[6:0] : mod_count;
    end
  end

  // list slots take the type identifier; memory has no reset
  always_ff @(posedge core_clk) begin
    if (mod_wr && mod_slot < node_cfg_pkg::MAX_MODULES[6:0]) begin
      mod_list[mod_slot] <= type_id(mod_type);
    end
  end

  // guard enable and lifetime limit in ms
  wire logic        guard_on  = guard_q != 16'h0000 && retry_q != 8'h00;
  wire logic [23:0] life_ms   = 24'(guard_q) * 24'(retry_q);
  wire logic        tick_end  = tick_q == 32'(MS_COUNT - 1);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      guard_tx_q  <= 1'b0;
      guard_cob_q <= node_cfg_pkg::GUARD_ID_BASE;
    end else begin
      guard_tx_q  <= guard_rx && guard_on;
      guard_cob_q <= node_cfg_pkg::GUARD_ID_BASE + {4'h0, node_id};
    end
  end

  // ms timebase and life monitor; run while guarding is on, restart at each request
  always_ff @(posedge core_clk) begin
    if (rst || !guard_on || guard_rx) begin
      tick_q    <= 32'h0000_0000;
      elapsed_q <= 24'h00_0000;
    end else if (tick_end) begin
      tick_q    <= 32'h0000_0000;
      elapsed_q <= (elapsed_q == life_ms) ? elapsed_q : elapsed_q + 24'd1;
    end else begin
      tick_q    <= tick_q + 32'd1;
    end
  end

  // life lost stays until the next request or until guarding is turned off; a request wins over expiry
  always_ff @(posedge core_clk) begin
    if (rst || !guard_on) begin
      armed_q     <= 1'b0;
      life_lost_q <= 1'b0;
    end else if (guard_rx) begin
      armed_q     <= 1'b1;
      life_lost_q <= 1'b0;
    end else if (armed_q && elapsed_q == life_ms) begin
      life_lost_q <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_ack_follows_req: assert property (od_req |=> od_ack_q)
    else $error("request not acknowledged next cycle");
  chk_sig_clear_write: assert property (cfg_change && !do_restore |=> sig_q == 64'h0)
    else $error("signature not cleared on configuration change");
  chk_restore_loads: assert property (do_restore |=> guard_q == $past(nv_image.guard)
                                      && sig_q == $past(nv_image.sig))
    else $error("restore did not load stored image");
  chk_err_reserved: assert property (err_q[3] == 1'b0 && err_q[5] == 1'b0
                                     && err_q[6] == 1'b0)
    else $error("reserved error bits set");
  chk_err_comm_bit: assert property (faults.comm |=> err_q[4])
    else $error("communication fault not reported");
  chk_guard_answer: assert property (guard_rx && guard_on |=> guard_tx_q)
    else $error("guard request not answered");
  chk_guard_disabled: assert property (!guard_on |=> !guard_tx_q && !life_lost_q)
    else $error("guarding active while disabled");
  chk_count_bound: assert property (count_q <= 7'd74)
    else $error("module count above list depth");
  chk_date_read: assert property (od_req && !od_cmd.wr && hit_sig
                                  && od_cmd.sub == 8'h01 |=> od_rdata_q == $past(sig_q.days))
    else $error("date read mismatch");
  chk_time_read: assert property (od_req && !od_cmd.wr && hit_sig
                                  && od_cmd.sub == 8'h02 |=> od_rdata_q == $past(sig_q.msecs))
    else $error("time read mismatch");
  chk_ro_write_abort: assert property (od_req && od_cmd.wr && hit_mods |=> od_abort_q)
    else $error("write to read-only list not refused");

  // dictionary answers: refusals carry no data and never touch settings
  chk_abort_with_ack: assert property (od_abort_q |-> od_ack_q)
    else $error("abort without acknowledge");
  chk_abort_no_data: assert property (od_abort_q |-> od_rdata_q == 32'h0000_0000)
    else $error("refused request returned data");
  chk_abort_keeps_cfg: assert property (od_req && req_bad && !do_restore
                                        |=> $stable(guard_q) && $stable(retry_q))
    else $error("refused request changed a setting");
  chk_count_read: assert property (od_req && !od_cmd.wr && hit_mods && sub0
                                   |=> od_rdata_q == {25'h0, $past(count_q)})
    else $error("module count read mismatch");
  chk_list_upper: assert property (od_req && !od_cmd.wr && hit_mods && mod_sel
                                   |=> od_rdata_q[31:16] == 16'h0000)
    else $error("module identifier upper half not zero");

  // signature save and restore, vendor fault bit
  chk_sig_write_lands: assert property (sig_wr && !cfg_change && !do_restore
                                        |=> sig_q == $past(sig_in))
    else $error("saved signature not stored");
  chk_restore_pulse: assert property (do_restore |=> restored_q)
    else $error("restore not reported");
  chk_err_vendor_bit: assert property (faults.vendor |=> err_q[7])
    else $error("vendor fault not reported");

  // guarding: no spurious answer, request clears loss, idle when off
  chk_guard_quiet: assert property (!(guard_rx && guard_on) |=> !guard_tx_q)
    else $error("guard answer without request");
  chk_guard_cob: assert property (1'b1 |=> guard_cob_q
                                  == node_cfg_pkg::GUARD_ID_BASE + {4'h0, $past(node_id)})
    else $error("guard answer identifier wrong");
  chk_life_cleared: assert property (guard_rx && guard_on |=> !life_lost_q)
    else $error("life loss not cleared by request");
  chk_disabled_idle: assert property (!guard_on |=> elapsed_q == 24'h00_0000)
    else $error("life monitor running while disabled");
endmodule

// ---- verif/guard_master.sv ----
// guarding master model that polls the node and counts missed answers
`timescale 1ns/1ps
module guard_master (
  // clock and control
  input  wire logic        core_clk,
  input  wire logic        en,
  input  wire logic [15:0] period,
  input  wire logic [7:0]  limit,
  // node side
  input  wire logic        guard_tx_q,
  output logic             guard_rx,
  output logic             not_ok
);
  int   cnt   = 0;
  int   fails = 0;
  logic got   = 1'b1;

  // polling off while disabled or either setting is zero
  wire logic idle = !en || period == 16'h0000 || limit == 8'h00;
  wire logic poll = !idle && (cnt + 1 >= int'(period));

  // node given up once misses reach the limit
  assign not_ok = (limit != 8'h00) && (fails >= int'(limit));

  // one request per period, raised just after the edge
  always @(posedge core_clk) begin
    guard_rx <= #1 poll;
  end

  // a poll whose predecessor went unanswered counts a timeout
  always @(posedge core_clk) begin
    if (idle) begin
      cnt   <= 0;
      fails <= 0;
      got   <= 1'b1;
    end else if (poll) begin
      cnt   <= 0;
      got   <= 1'b0;
      fails <= got ? 0 : fails + 1;
    end else begin
      cnt   <= cnt + 1;
      got   <= got || guard_tx_q;
    end
  end
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the node configuration and guard objects
`timescale 1ns/1ps
module tb;
  localparam int MSC = 4;
  logic core_clk, rst, od_req, sig_wr, auto_restore, restore_req, mod_wr;
  logic rx_tb, prx, pen, not_ok;
  logic od_ack_q, od_abort_q, restored_q, guard_tx_q, life_lost_q;
  logic [6:0]  mod_slot, mod_count, node_id;
  logic [7:0]  mod_type, lim;
  logic [15:0] gval;
  logic [31:0] od_rdata_q, rd;
  logic [10:0] guard_cob_q;
  logic [7:0]  types [0:73];
  integer      seed, err_total, num_checks, i;
  node_cfg_pkg::od_req_type    od_cmd;
  node_cfg_pkg::signature_type sig_in;
  node_cfg_pkg::nv_image_type  nv_image;
  node_cfg_pkg::fault_type     faults;

  node_config_guard_objects #(.MS_COUNT(MSC)) dut (.core_clk, .rst, .od_req, .od_cmd,
    .od_ack_q, .od_abort_q, .od_rdata_q, .sig_wr, .sig_in, .nv_image, .auto_restore,
    .restore_req, .restored_q, .mod_wr, .mod_slot, .mod_type, .mod_count, .faults,
    .node_id, .guard_rx(prx | rx_tb), .guard_tx_q, .guard_cob_q, .life_lost_q);
  guard_master pm (.core_clk, .en(pen), .period(gval * 16'(MSC)), .limit(lim),
    .guard_tx_q, .guard_rx(prx), .not_ok);

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic tick;
    @(posedge core_clk) #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one dictionary request, answer sampled the cycle after it is taken
  task automatic acc(input logic w, input logic [15:0] x, input logic [7:0] s,
                     input logic [31:0] d, input logic ea);
    tick;
    od_req = 1'b1;
    od_cmd = '{w, x, s, d};
    tick;
    od_req = 1'b0;
    check(od_ack_q, 1);
    check(od_abort_q, ea);
    rd = od_rdata_q;
  endtask

  function automatic logic [31:0] mod_id(input logic [7:0] t);
    return {16'h0000, node_cfg_pkg::MODULE_ID_BASE + 16'(t)};
  endfunction

  function automatic logic [31:0] err_byte(input node_cfg_pkg::fault_type f);
    return {24'h0, f.vendor, 2'b00, f.comm, 1'b0, f.voltage, f.current, f.general};
  endfunction

  task automatic give_verdict;
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    give_verdict;
  end

  initial begin
    seed = 32'hd6f7;
    err_total = 0;
    num_checks = 0;
    {od_req, sig_wr, restore_req, mod_wr, rx_tb, pen, od_cmd, sig_in, faults} = '0;
    {mod_slot, mod_type, gval, lim} = '0;
    rst = 1'b1;
    auto_restore = 1'b1;
    mod_count = 7'd74;
    node_id = 7'($random(seed));
    nv_image = '{1'b1, '{$random(seed), $random(seed)}, 16'($random(seed)), 8'h05};
    repeat (3) tick;
    rst = 1'b0;
    acc(0, node_cfg_pkg::IDX_GUARD, 8'h00, 0, 0);
    check(rd, {16'h0, nv_image.guard});
    acc(0, node_cfg_pkg::IDX_SIG, node_cfg_pkg::SUB_DATE, 0, 0);
    check(rd, nv_image.sig.days);
    acc(0, node_cfg_pkg::IDX_SIG, node_cfg_pkg::SUB_COUNT, 0, 0);
    check(rd, 32'h0000_0002);
    // signature saved by the tool, both halves readable apart
    tick;
    sig_in = '{$random(seed), $random(seed)};
    sig_wr = 1'b1;
    tick;
    sig_wr = 1'b0;
    acc(0, node_cfg_pkg::IDX_SIG, node_cfg_pkg::SUB_DATE, 0, 0);
    check(rd, sig_in.days);
    acc(0, node_cfg_pkg::IDX_SIG, node_cfg_pkg::SUB_TIME, 0, 0);
    check(rd, sig_in.msecs);
    // a config write wipes the signature, a restore brings it back
    gval = 16'($random(seed));
    acc(1, node_cfg_pkg::IDX_GUARD, 8'h00, {16'h0, gval}, 0);
    acc(0, node_cfg_pkg::IDX_GUARD, 8'h00, 0, 0);
    check(rd, {16'h0, gval});
    acc(0, node_cfg_pkg::IDX_SIG, node_cfg_pkg::SUB_DATE, 0, 0);
    check(rd, 32'h0000_0000);
    tick;
    restore_req = 1'b1;
    tick;
    restore_req = 1'b0;
    check(restored_q, 1);
    acc(0, node_cfg_pkg::IDX_SIG, node_cfg_pkg::SUB_TIME, 0, 0);
    check(rd, nv_image.sig.msecs);
    acc(1, node_cfg_pkg::IDX_RETRY, 8'h00, 32'h0000_00A5, 0);
    acc(0, node_cfg_pkg::IDX_SIG, node_cfg_pkg::SUB_TIME, 0, 0);
    check(rd, 32'h0000_0000);
    // refused accesses: read-only byte, unmapped index, sub beyond signature
    acc(1, node_cfg_pkg::IDX_ERROR, 8'h00, 32'h0000_0005, 1);
    acc(0, 16'h1002, 8'h00, 0, 1);
    acc(0, node_cfg_pkg::IDX_SIG, 8'h03, 0, 1);
    // fault levels mapped into the error byte, spare bits low
    for (i = 0; i < 8; i++) begin
      faults = 5'($random(seed));
      tick;
      acc(0, node_cfg_pkg::IDX_ERROR, 8'h00, 0, 0);
      check(rd, err_byte(faults));
    end
    // fill all 74 slots back to back, first two of one type
    for (i = 0; i < 74; i++) begin
      types[i] = (i == 1) ? types[0] : 8'($random(seed));
      tick;
      mod_wr = 1'b1;
      mod_slot = 7'(i);
      mod_type = types[i];
    end
    tick;
    mod_wr = 1'b0;
    acc(0, node_cfg_pkg::IDX_MODULES, 8'h00, 0, 0);
    check(rd, 32'd74);
    for (i = 0; i < 74; i++) begin
      acc(0, node_cfg_pkg::IDX_MODULES, 8'(i + 1), 0, 0);
      check(rd, mod_id(types[i]));
    end
    acc(1, node_cfg_pkg::IDX_MODULES, 8'h00, 32'h0000_0003, 1);
    mod_count = 7'd3;
    tick;
    acc(0, node_cfg_pkg::IDX_MODULES, 8'h04, 0, 1);
    acc(0, node_cfg_pkg::IDX_MODULES, 8'h00, 0, 0);
    check(rd, 32'd3);
    // second reset, no valid image: nothing comes back, manager reconfigures
    rst = 1'b1;
    auto_restore = 1'b0;
    nv_image.valid = 1'b0;
    repeat (3) tick;
    rst = 1'b0;
    tick;
    restore_req = 1'b1;
    tick;
    restore_req = 1'b0;
    check(restored_q, 0);
    acc(0, node_cfg_pkg::IDX_SIG, node_cfg_pkg::SUB_DATE, 0, 0);
    check(rd, 32'h0000_0000);
    // signature differs from the manager's file: rewrite and re-sign
    if (rd !== nv_image.sig.days) begin
      acc(1, node_cfg_pkg::IDX_GUARD, 8'h00, {16'h0, nv_image.guard}, 0);
      tick;
      sig_in = nv_image.sig;
      sig_wr = 1'b1;
      tick;
      sig_wr = 1'b0;
    end
    acc(0, node_cfg_pkg::IDX_GUARD, 8'h00, 0, 0);
    check(rd, {16'h0, nv_image.guard});
    acc(0, node_cfg_pkg::IDX_SIG, node_cfg_pkg::SUB_TIME, 0, 0);
    check(rd, nv_image.sig.msecs);
    // guarding with 1 ms interval and two misses allowed
    gval = 16'h0001;
    lim = 8'h02;
    acc(1, node_cfg_pkg::IDX_GUARD, 8'h00, 32'h0000_0001, 0);
    acc(1, node_cfg_pkg::IDX_RETRY, 8'h00, 32'h0000_0002, 0);
    pen = 1'b1;
    repeat (30) tick;
    check(not_ok, 0);
    check(life_lost_q, 0);
    check(guard_cob_q, {21'h0, node_cfg_pkg::GUARD_ID_BASE + 11'(node_id)});
    pen = 1'b0;
    repeat (14) tick;
    check(life_lost_q, 1);
    rx_tb = 1'b1;
    tick;
    rx_tb = 1'b0;
    check(guard_tx_q, 1);
    check(life_lost_q, 0);
    // zero factor turns guarding off: no answer, no loss
    acc(1, node_cfg_pkg::IDX_RETRY, 8'h00, 0, 0);
    tick;
    rx_tb = 1'b1;
    tick;
    rx_tb = 1'b0;
    check(guard_tx_q, 0);
    // master keeps polling a silent node and gives it up after two misses
    pen = 1'b1;
    repeat (14) tick;
    check(life_lost_q, 0);
    check(not_ok, 1);
    give_verdict;
  end
endmodule
